// ===== hw/cfg_regs.svh
`ifndef CFG_REGS_SVH
`define CFG_REGS_SVH

// Word offsets on the register port
`define CFG_OFS_MODE 8'h00
`define CFG_OFS_IDENT 8'h04
`define CFG_OFS_MP_IRQ_EN 8'h08
`define CFG_OFS_MP_LEVEL 8'h0C
`define CFG_OFS_MP_TRI 8'h10
`define CFG_OFS_MP_INV 8'h14
`define CFG_OFS_MP_DIR 8'h18
`define CFG_OFS_MP_OD 8'h1C

// Field positions in the mode word
`define CFG_POS_8X 0
`define CFG_POS_4X 8
`define CFG_POS_RST 16
`define CFG_POS_SLEEP 24

// Field positions in the identity and control word
`define CFG_POS_REV 0
`define CFG_POS_ID 8
`define CFG_POS_SIMUL 16
`define CFG_POS_NO_WAKE 17
`define CFG_POS_GLOBAL_DIS 18
`define CFG_POS_EE_ERR 19
`define CFG_POS_EE_CLK 20
`define CFG_POS_EE_CS 21
`define CFG_POS_EE_DI 22
`define CFG_POS_EE_DO 23

// Reset values
`define CFG_RST_CHAN 2'h0
`define CFG_RST_CTRL 3'h0
`define CFG_RST_EE 3'h0
`define CFG_RST_MP 16'h0000
`define CFG_RST_MP_DIR 16'hFFFF

`endif

// ===== hw/cfg_pkg.sv
package cfg_pkg;

    typedef enum logic {
        SLP_AWAKE,
        SLP_ASLEEP
    } sleep_state_t;

    // Per-channel status from the UART core, same clock
    typedef struct packed {
        logic tx_empty;
        logic rx_data_ready;
        logic infrared_mode;
        logic multidrop;
        logic rx_disabled;
        logic [3:0] modem_delta;
        logic tx_load;
        logic irq_pending;
    } chan_status_t;

endpackage

// ===== hw/sleep_ctrl.sv
`timescale 1ns/1ns
module sleep_ctrl (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sleep_en,
    input wire logic chan_reset,
    input wire cfg_pkg::chan_status_t status,
    input wire logic rx_pin,
    input wire logic wake_any,
    output logic wake_event,
    output logic asleep
);
    logic rx_s1_q, rx_s2_q, rx_prev_q;
    logic [3:0] delta_prev_q;
    cfg_pkg::sleep_state_t state_q, state_d;
    logic rx_start, rx_idle, can_sleep;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_prev_q <= 1'b1;
            delta_prev_q <= 4'h0;
        end else begin
            rx_s1_q <= rx_pin;
            rx_s2_q <= rx_s1_q;
            rx_prev_q <= rx_s2_q;
            delta_prev_q <= status.modem_delta;
        end
    end

    always_comb begin
        // Start bit: falling normally, rising in infrared mode
        rx_start = status.infrared_mode ? (rx_s2_q & ~rx_prev_q) : (~rx_s2_q & rx_prev_q);
        // A disabled receiver outside multidrop ignores the line
        if (!status.multidrop && status.rx_disabled) begin
            rx_start = 1'b0;
        end
        wake_event = rx_start | status.tx_load | (|(status.modem_delta & ~delta_prev_q));
        rx_idle = status.infrared_mode ? ~rx_s2_q : rx_s2_q;
        can_sleep = sleep_en & status.tx_empty & ~status.rx_data_ready & rx_idle
            & (status.modem_delta == 4'h0) & ~status.irq_pending;
        state_d = state_q;
        case (state_q)
            cfg_pkg::SLP_AWAKE: begin
                if (can_sleep && !wake_any) begin
                    state_d = cfg_pkg::SLP_ASLEEP;
                end
            end
            cfg_pkg::SLP_ASLEEP: begin
                if (wake_any || !can_sleep) begin
                    state_d = cfg_pkg::SLP_AWAKE;
                end
            end
            default: state_d = cfg_pkg::SLP_AWAKE;
        endcase
        if (chan_reset) begin
            state_d = cfg_pkg::SLP_AWAKE;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= cfg_pkg::SLP_AWAKE;
        end else begin
            state_q <= state_d;
        end
    end

    assign asleep = (state_q == cfg_pkg::SLP_ASLEEP);
endmodule

// ===== hw/multi_purpose_pin_pin.sv
`timescale 1ns/1ns
module multi_purpose_pin_pin (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pin_in,
    input wire logic is_input,
    input wire logic invert,
    input wire logic irq_en,
    input wire logic level,
    input wire logic tristate,
    input wire logic open_drain,
    input wire logic timer_route,
    input wire logic timer_out,
    output logic pin_out,
    output logic pin_oe,
    output logic level_in,
    output logic irq_event
);
    logic s1_q, s2_q, prev_q;
    logic out_d, oe_d, out_q, oe_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            prev_q <= level_in;
        end
    end

    always_comb begin
        level_in = s2_q ^ invert;
        // Edge-sensed on the inverted level; outputs never interrupt
        irq_event = irq_en & is_input & ~timer_route & level_in & ~prev_q;
        if (timer_route) begin
            // Timer owns the pin; its idle level is high
            out_d = timer_out;
            oe_d = 1'b1;
        end else if (is_input || tristate) begin
            out_d = 1'b0;
            oe_d = 1'b0;
        end else if (open_drain) begin
            out_d = 1'b0;
            oe_d = ~level;
        end else begin
            out_d = level;
            oe_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    assign pin_out = out_q;
    assign pin_oe = oe_q;
endmodule

// ===== hw/dual_uart_device_config_regs.sv
`timescale 1ns/1ns
`include "cfg_regs.svh"

// Summary of operation
// - Channel bit selects eight-times sampling
// - Channel writes only its own bit
// - Channel bit selects four-times sampling
// - Reset bit resets channel, self-clears
// - Sleep enable bit permits channel sleep
// - Sleep needs idle transmitter, receiver, modem
// - Start bit, tx load, delta wake
// - Disabled receiver start bit wakes only in multidrop
// - Wake raises interrupt with no source
// - Re-sleep automatically once UART interrupts clear; wake flag ignored
// - Read-only identity and revision bytes
// - Control bit sixteen writes both channels
// - Control bit seventeen suppresses wake interrupt
// - Control bit eighteen blocks host interrupts
// - Bit nineteen reports EEPROM load failure
// - Bits twenty to twenty-three bit-bang EEPROM
// - Sixteen pins: inversion, interrupt, output modes
// - Pin interrupts ORed into the host interrupt
// - Timer routing overrides pin zero controls
// - Timer routing drives timer output on pin zero
module dual_uart_device_config_regs #(
    parameter int CHANNELS = 2,
    parameter int PINS = 16,
    parameter logic [7:0] IDENTITY = 8'h5A,
    parameter logic [7:0] REVISION = 8'h03
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic bus_channel,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire cfg_pkg::chan_status_t [1:0] chan_status,
    input wire logic [1:0] rx_pin,
    input wire logic eeprom_load_error,
    input wire logic eeprom_serial_out,
    output logic eeprom_serial_clock,
    output logic eeprom_chip_select,
    output logic eeprom_serial_in,
    output logic [1:0] sample_8x_select,
    output logic [1:0] sample_4x_select,
    output logic [1:0] chan_reset,
    output logic [1:0] chan_asleep,
    output logic [1:0] wake_irq,
    output logic multi_purpose_pin_irq,
    output logic host_irq,
    input wire logic timer_route,
    input wire logic timer_out,
    input wire logic [15:0] multi_purpose_pin_in,
    output logic [15:0] multi_purpose_pin_out,
    output logic [15:0] multi_purpose_pin_oe
);
    // Arbitrary identification values, not tied to any part
    localparam logic [7:0] ID_VALUE = IDENTITY;
    localparam logic [7:0] REV_VALUE = REVISION;

    logic [1:0] x8_q, x8_d, x4_q, x4_d, sleep_q, sleep_d, rst_q, rst_d;
    logic [1:0] wake_q, wake_d;
    logic [2:0] ctrl_q, ctrl_d, ee_q, ee_d;
    logic [15:0] mp_irq_en_q, mp_irq_en_d, mp_level_q, mp_level_d;
    logic [15:0] mp_tri_q, mp_tri_d, mp_inv_q, mp_inv_d;
    logic [15:0] mp_dir_q, mp_dir_d, mp_od_q, mp_od_d;
    logic mp_flag_q, mp_flag_d;
    logic ee_do_s1_q, ee_do_s2_q;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] own_mask, wake_ev;
    logic [15:0] level_in, pin_ev, level_view;
    logic wake_any;

    // Simultaneous write opens both channel bits
    assign own_mask = ctrl_q[0] ? 2'b11 : (bus_channel ? 2'b10 : 2'b01);
    assign wake_any = |wake_ev;

    // Mode, sleep, reset and wake state
    always_comb begin
        x8_d = x8_q;
        x4_d = x4_q;
        sleep_d = sleep_q;
        rst_d = 2'b00;
        if (wr_en && addr == `CFG_OFS_MODE) begin
            x8_d = (x8_q & ~own_mask) | (wdata[`CFG_POS_8X +: 2] & own_mask);
            x4_d = (x4_q & ~own_mask) | (wdata[`CFG_POS_4X +: 2] & own_mask);
            sleep_d = (sleep_q & ~own_mask) | (wdata[`CFG_POS_SLEEP +: 2] & own_mask);
            rst_d = wdata[`CFG_POS_RST +: 2] & own_mask;
        end
        // Channel reset returns its mode and sleep bits to default
        x8_d = x8_d & ~rst_q;
        x4_d = x4_d & ~rst_q;
        sleep_d = sleep_d & ~rst_q;
        wake_d = wake_q;
        if (rd_en && addr == `CFG_OFS_MODE) begin
            wake_d = wake_q & ~own_mask;
        end
        wake_d = wake_d & ~rst_q;
        // Set wins over the clearing read; the event is seen while still asleep
        if (!ctrl_q[1]) begin
            wake_d = wake_d | (chan_asleep & {2{wake_any}});
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            x8_q <= `CFG_RST_CHAN;
            x4_q <= `CFG_RST_CHAN;
            sleep_q <= `CFG_RST_CHAN;
            rst_q <= `CFG_RST_CHAN;
            wake_q <= `CFG_RST_CHAN;
        end else begin
            x8_q <= x8_d;
            x4_q <= x4_d;
            sleep_q <= sleep_d;
            rst_q <= rst_d;
            wake_q <= wake_d;
        end
    end

    // Global control and EEPROM bit-bang pins
    always_comb begin
        ctrl_d = ctrl_q;
        ee_d = ee_q;
        if (wr_en && addr == `CFG_OFS_IDENT) begin
            ctrl_d = wdata[`CFG_POS_SIMUL +: 3];
            ee_d = wdata[`CFG_POS_EE_CLK +: 3];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `CFG_RST_CTRL;
            ee_q <= `CFG_RST_EE;
            ee_do_s1_q <= 1'b0;
            ee_do_s2_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            ee_q <= ee_d;
            ee_do_s1_q <= eeprom_serial_out;
            ee_do_s2_q <= ee_do_s1_q;
        end
    end

    // Multi-purpose pin control
    always_comb begin
        mp_irq_en_d = mp_irq_en_q;
        mp_level_d = mp_level_q;
        mp_tri_d = mp_tri_q;
        mp_inv_d = mp_inv_q;
        mp_dir_d = mp_dir_q;
        mp_od_d = mp_od_q;
        if (wr_en) begin
            case (addr)
                `CFG_OFS_MP_IRQ_EN: mp_irq_en_d = wdata[15:0];
                `CFG_OFS_MP_LEVEL: mp_level_d = wdata[15:0];
                `CFG_OFS_MP_TRI: mp_tri_d = wdata[15:0];
                `CFG_OFS_MP_INV: mp_inv_d = wdata[15:0];
                `CFG_OFS_MP_DIR: mp_dir_d = wdata[15:0];
                `CFG_OFS_MP_OD: mp_od_d = wdata[15:0];
                default: mp_od_d = mp_od_q;
            endcase
        end
        // Reading the level view clears the shared flag; a new edge still sets it
        mp_flag_d = mp_flag_q;
        if (rd_en && addr == `CFG_OFS_MP_LEVEL) begin
            mp_flag_d = 1'b0;
        end
        mp_flag_d = mp_flag_d | (|pin_ev);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mp_irq_en_q <= `CFG_RST_MP;
            mp_level_q <= `CFG_RST_MP;
            mp_tri_q <= `CFG_RST_MP;
            mp_inv_q <= `CFG_RST_MP;
            mp_dir_q <= `CFG_RST_MP_DIR;
            mp_od_q <= `CFG_RST_MP;
            mp_flag_q <= 1'b0;
        end else begin
            mp_irq_en_q <= mp_irq_en_d;
            mp_level_q <= mp_level_d;
            mp_tri_q <= mp_tri_d;
            mp_inv_q <= mp_inv_d;
            mp_dir_q <= mp_dir_d;
            mp_od_q <= mp_od_d;
            mp_flag_q <= mp_flag_d;
        end
    end

    for (genvar p = 0; p < PINS; p++) begin : g_pin
        multi_purpose_pin_pin u_pin (
            .clk(clk),
            .arst_n(arst_n),
            .pin_in(multi_purpose_pin_in[p]),
            .is_input(mp_dir_q[p]),
            .invert(mp_inv_q[p]),
            .irq_en(mp_irq_en_q[p]),
            .level(mp_level_q[p]),
            .tristate(mp_tri_q[p]),
            .open_drain(mp_od_q[p]),
            .timer_route((p == 0) ? timer_route : 1'b0),
            .timer_out(timer_out),
            .pin_out(multi_purpose_pin_out[p]),
            .pin_oe(multi_purpose_pin_oe[p]),
            .level_in(level_in[p]),
            .irq_event(pin_ev[p])
        );
    end

    // Inputs show the pin after inversion, outputs the programmed level
    assign level_view = (level_in & mp_dir_q) | (mp_level_q & ~mp_dir_q);

    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
        sleep_ctrl u_sleep (
            .clk(clk),
            .arst_n(arst_n),
            .sleep_en(sleep_q[c]),
            .chan_reset(rst_q[c]),
            .status(chan_status[c]),
            .rx_pin(rx_pin[c]),
            .wake_any(wake_any),
            .wake_event(wake_ev[c]),
            .asleep(chan_asleep[c])
        );
    end

    // Read data, one cycle after the strobe
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd_en) begin
            case (addr)
                `CFG_OFS_MODE: begin
                    rdata_d[`CFG_POS_8X +: 2] = x8_q;
                    rdata_d[`CFG_POS_4X +: 2] = x4_q;
                    rdata_d[`CFG_POS_RST +: 2] = rst_q;
                    rdata_d[`CFG_POS_SLEEP +: 2] = sleep_q;
                end
                `CFG_OFS_IDENT: begin
                    rdata_d[`CFG_POS_REV +: 8] = REV_VALUE;
                    rdata_d[`CFG_POS_ID +: 8] = ID_VALUE;
                    rdata_d[`CFG_POS_SIMUL +: 3] = ctrl_q;
                    rdata_d[`CFG_POS_EE_ERR] = eeprom_load_error;
                    rdata_d[`CFG_POS_EE_DO] = ee_do_s2_q;
                end
                `CFG_OFS_MP_IRQ_EN: rdata_d[15:0] = mp_irq_en_q;
                `CFG_OFS_MP_LEVEL: rdata_d[15:0] = level_view;
                `CFG_OFS_MP_TRI: rdata_d[15:0] = mp_tri_q;
                `CFG_OFS_MP_INV: rdata_d[15:0] = mp_inv_q;
                `CFG_OFS_MP_DIR: rdata_d[15:0] = mp_dir_q;
                `CFG_OFS_MP_OD: rdata_d[15:0] = mp_od_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign sample_8x_select = x8_q;
    assign sample_4x_select = x4_q;
    assign chan_reset = rst_q;
    assign wake_irq = wake_q;
    assign multi_purpose_pin_irq = mp_flag_q;
    assign eeprom_serial_clock = ee_q[0];
    assign eeprom_chip_select = ee_q[1];
    assign eeprom_serial_in = ee_q[2];
    // Wake flags and pin interrupt are channel sources too
    assign host_irq = ~ctrl_q[2] & (chan_status[0].irq_pending | chan_status[1].irq_pending
        | (|wake_q) | mp_flag_q);
endmodule

// ===== dv/cfg_regs_chk.sv
`timescale 1ns/1ns
module cfg_regs_chk #(
    parameter logic [7:0] IDENTITY = 8'h5A,
    parameter logic [7:0] REVISION = 8'h03
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic bus_channel,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    input wire cfg_pkg::chan_status_t [1:0] chan_status,
    input wire logic eeprom_load_error,
    input wire logic eeprom_serial_clock,
    input wire logic eeprom_chip_select,
    input wire logic [1:0] sample_8x_select,
    input wire logic [1:0] sample_4x_select,
    input wire logic [1:0] chan_reset,
    input wire logic [1:0] chan_asleep,
    input wire logic [1:0] wake_irq,
    input wire logic multi_purpose_pin_irq,
    input wire logic host_irq,
    input wire logic timer_route,
    input wire logic timer_out,
    input wire logic [15:0] multi_purpose_pin_out,
    input wire logic [15:0] multi_purpose_pin_oe
);
    logic [2:0] ctrl_q;
    logic [2:0] ctrl_d;
    // Shadow of the control bits so checks need no bus decode of their own
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_en && addr == 8'h04) begin
            ctrl_d = wdata[18:16];
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= 3'h0;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    property p_own_8x;
        wr_en && addr == 8'h00 && !bus_channel && !chan_reset[0] |=> sample_8x_select[0] == $past(wdata[0]);
    endproperty
    a_own_8x: assert property (p_own_8x) else $error("8x bit not written");
    property p_other_ro;
        wr_en && addr == 8'h00 && bus_channel && !ctrl_q[0] && !chan_reset[0] |=> $stable(sample_8x_select[0]);
    endproperty
    a_other_ro: assert property (p_other_ro) else $error("foreign bit changed");
    property p_own_4x;
        wr_en && addr == 8'h00 && !bus_channel && !chan_reset[0] |=> sample_4x_select[0] == $past(wdata[8]);
    endproperty
    a_own_4x: assert property (p_own_4x) else $error("4x bit not written");
    property p_rst;
        chan_reset[1] |=> !chan_reset[1] && !sample_8x_select[1] && !sample_4x_select[1];
    endproperty
    a_rst: assert property (p_rst) else $error("channel reset wrong");
    property p_ident;
        rd_en && addr == 8'h04 |=> rdata[15:0] == {IDENTITY, REVISION} && rdata[19] == $past(eeprom_load_error);
    endproperty
    a_ident: assert property (p_ident) else $error("identity word wrong");
    property p_ee;
        wr_en && addr == 8'h04 |=> eeprom_serial_clock == $past(wdata[20]) && eeprom_chip_select == $past(wdata[21]);
    endproperty
    a_ee: assert property (p_ee) else $error("eeprom pins wrong");
    property p_gdis;
        ctrl_q[2] |-> !host_irq;
    endproperty
    a_gdis: assert property (p_gdis) else $error("host irq not blocked");
    // Bit must already have stood a cycle, as the design sets the flag from its old value
    property p_nowake;
        ctrl_q[1] && $past(ctrl_q[1]) && !$past(wake_irq[0]) |-> !wake_irq[0];
    endproperty
    a_nowake: assert property (p_nowake) else $error("wake irq not suppressed");
    property p_entry;
        $rose(chan_asleep[0]) |-> $past(chan_status[0].tx_empty && chan_status[0].modem_delta == 4'h0);
    endproperty
    a_entry: assert property (p_entry) else $error("sleep without idle");
    property p_timer;
        timer_route |=> multi_purpose_pin_oe[0] && multi_purpose_pin_out[0] == $past(timer_out);
    endproperty
    a_timer: assert property (p_timer) else $error("timer pin wrong");
    c_sleep: cover property ($rose(chan_asleep[0]));
    c_wake: cover property ($rose(wake_irq[0]));
    c_multi_purpose_pin: cover property ($rose(multi_purpose_pin_irq));
endmodule
bind dual_uart_device_config_regs cfg_regs_chk #(.IDENTITY(IDENTITY), .REVISION(REVISION)) cfg_regs_chk_inst (
    .clk(clk), .arst_n(arst_n), .addr(addr), .bus_channel(bus_channel), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .chan_status(chan_status), .eeprom_load_error(eeprom_load_error),
    .eeprom_serial_clock(eeprom_serial_clock),
    .eeprom_chip_select(eeprom_chip_select), .sample_8x_select(sample_8x_select),
    .sample_4x_select(sample_4x_select), .chan_reset(chan_reset), .chan_asleep(chan_asleep),
    .wake_irq(wake_irq), .multi_purpose_pin_irq(multi_purpose_pin_irq), .host_irq(host_irq), .timer_route(timer_route),
    .timer_out(timer_out), .multi_purpose_pin_out(multi_purpose_pin_out),
    .multi_purpose_pin_oe(multi_purpose_pin_oe)
);

// ===== dv/dual_uart_device_config_regs_test.sv
`timescale 1ns/1ns
module dual_uart_device_config_regs_test;
    localparam logic [7:0] IDENT = 8'hC3; // Arbitrary value
    localparam logic [7:0] REV = 8'h07; // Arbitrary value
    logic clk, arst_n, bus_channel, wr_en, rd_en, ee_err, ee_do, ee_clk, ee_cs, ee_di;
    logic multi_purpose_pin_irq, host_irq, timer_route, timer_out;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [1:0] rx_pin, s8, s4, chan_reset, chan_asleep, wake_irq;
    logic [15:0] mp_in, mp_out, mp_oe;
    cfg_pkg::chan_status_t [1:0] chan_status;
    int bad_count = 0;
    int n_compared = 0;
    dual_uart_device_config_regs #(.IDENTITY(IDENT), .REVISION(REV)) dual_uart_device_config_regs_inst (
        .clk(clk), .arst_n(arst_n), .addr(addr), .bus_channel(bus_channel), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .chan_status(chan_status), .rx_pin(rx_pin), .eeprom_load_error(ee_err),
        .eeprom_serial_out(ee_do), .eeprom_serial_clock(ee_clk), .eeprom_chip_select(ee_cs),
        .eeprom_serial_in(ee_di), .sample_8x_select(s8), .sample_4x_select(s4), .chan_reset(chan_reset),
        .chan_asleep(chan_asleep), .wake_irq(wake_irq), .multi_purpose_pin_irq(multi_purpose_pin_irq), .host_irq(host_irq),
        .timer_route(timer_route), .timer_out(timer_out), .multi_purpose_pin_in(mp_in),
        .multi_purpose_pin_out(mp_out), .multi_purpose_pin_oe(mp_oe)
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic conclude();
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic ch, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_channel <= ch;
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic ch, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus_channel <= ch;
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // Bounded wait on a status flag; a miss ends the run
    task automatic poll(input int sel, input logic exp, input int lim);
        logic v;
        n_compared++;
        repeat (lim) begin
            @(posedge clk);
            #1;
            v = (sel == 0) ? chan_asleep[0] : (sel == 1) ? wake_irq[0] : multi_purpose_pin_irq;
            if (v === exp) begin
                return;
            end
        end
        bad_count++;
        $display("wrong value at %0t: flag %0d never reached %b", $time, sel, exp);
        conclude();
    endtask
    initial begin
        arst_n = 1'b0;
        addr = 8'h00;
        bus_channel = 1'b0;
        wdata = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        chan_status = '0;
        chan_status[1].tx_empty = 1'b1;
        rx_pin = 2'b11;
        ee_err = 1'b1;
        ee_do = 1'b1;
        timer_route = 1'b0;
        timer_out = 1'b1;
        mp_in = 16'h0000;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(0, 8'h04, {16'h0088, IDENT, REV});
        rd(0, 8'h18, 32'h0000_FFFF);
        rd(0, 8'h40, 32'h0);
        wr(0, 8'h00, 32'h0000_0003);
        wr(1, 8'h00, 32'h0000_0300);
        chk(32'({s4, s8}), 32'h9);
        rd(1, 8'h00, 32'h0000_0201);
        wr(0, 8'h04, 32'h0001_0000);
        wr(0, 8'h00, 32'h0000_0300);
        chk(32'({s4, s8}), 32'hC);
        wr(0, 8'h04, 32'h0070_0000);
        chk(32'({ee_di, ee_cs, ee_clk}), 32'h7);
        rd(0, 8'h04, {16'h0088, IDENT, REV});
        wr(0, 8'h04, 32'h0);
        wr(1, 8'h00, 32'h0002_0200);
        chk(32'(chan_reset), 32'h2);
        @(posedge clk);
        #1;
        chk(32'({chan_reset, s4}), 32'h1);
        wr(0, 8'h00, 32'h0100_0000);
        repeat (3) @(posedge clk);
        #1;
        chk(32'(chan_asleep), 32'h0);
        @(posedge clk);
        chan_status[0].tx_empty <= 1'b1;
        poll(0, 1'b1, 6);
        chk(32'(chan_asleep), 32'h1);
        @(posedge clk);
        chan_status[1].tx_load <= 1'b1;
        @(posedge clk);
        chan_status[1].tx_load <= 1'b0;
        // Idle channel sleeps again one edge later, so look now
        #1;
        chk(32'(chan_asleep[0]), 32'h0);
        poll(1, 1'b1, 5);
        chk(32'(host_irq), 32'h1);
        poll(0, 1'b1, 10);
        rd(0, 8'h00, 32'h0100_0000);
        chk(32'({host_irq, wake_irq}), 32'h0);
        wr(0, 8'h04, 32'h0004_0000);
        @(posedge clk);
        rx_pin[0] <= 1'b0;
        poll(1, 1'b1, 8);
        chk(32'(host_irq), 32'h0);
        @(posedge clk);
        rx_pin[0] <= 1'b1;
        wr(0, 8'h04, 32'h0);
        chk(32'(host_irq), 32'h1);
        rd(0, 8'h00, 32'h0100_0000);
        poll(0, 1'b1, 10);
        wr(0, 8'h04, 32'h0002_0000);
        @(posedge clk);
        chan_status[0].modem_delta <= 4'h1;
        poll(0, 1'b0, 5);
        chk(32'(wake_irq), 32'h0);
        @(posedge clk);
        chan_status[0].modem_delta <= 4'h0;
        poll(0, 1'b1, 10);
        wr(0, 8'h04, 32'h0);
        @(posedge clk);
        chan_status[1].rx_disabled <= 1'b1;
        rx_pin[1] <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk(32'(chan_asleep[0]), 32'h1);
        @(posedge clk);
        rx_pin[1] <= 1'b1;
        wr(0, 8'h00, 32'h0);
        poll(0, 1'b0, 3);
        wr(0, 8'h18, 32'h0000_FFFD);
        wr(0, 8'h0C, 32'h0000_0002);
        @(posedge clk);
        #1;
        chk(32'({mp_oe[1], mp_out[1]}), 32'h3);
        wr(0, 8'h1C, 32'h0000_0002);
        @(posedge clk);
        #1;
        chk(32'({mp_oe[1], mp_out[1]}), 32'h0);
        wr(0, 8'h08, 32'h0000_0004);
        @(posedge clk);
        mp_in[2] <= 1'b1;
        poll(2, 1'b1, 8);
        rd(0, 8'h0C, 32'h0000_0006);
        chk(32'(multi_purpose_pin_irq), 32'h0);
        wr(0, 8'h14, 32'h0000_0004);
        repeat (3) @(posedge clk);
        rd(0, 8'h0C, 32'h0000_0002);
        @(posedge clk);
        timer_route <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(32'({mp_oe[0], mp_out[0]}), 32'h3);
        conclude();
    end
endmodule
